// >>> core/qfb_pkg.sv
package qfb_pkg;

  // ------------------------------------------------------------
  // Command word layout
  // ------------------------------------------------------------
  localparam int TYPE_MSB = 11;
  localparam int TYPE_LSB = 8;
  localparam int KIND_MSB = 1;
  localparam int KIND_LSB = 0;

  typedef enum logic [1:0] {
    KIND_HEADER,
    KIND_INTER,
    KIND_LAST,
    KIND_CLEAR
  } qfb_kind_t;

  // ------------------------------------------------------------
  // Frame geometry
  // ------------------------------------------------------------
  localparam int SYNC_SYMBOLS  = 24;
  localparam int PAD_SYMBOLS   = 16;
  localparam int PAD_W         = $clog2(PAD_SYMBOLS);
  localparam int HDR_CRC_BYTES = 2;
  localparam int FRM_CRC_BYTES = 4;
  localparam int NUM_TYPES     = 12;
  localparam int SIZE_W        = 9;
  localparam int RATE_W        = 7;
  localparam logic [3:0] USER_TYPE = 4'hc;
  localparam logic [1:0] QAM_32    = 2'h2;
  localparam logic [1:0] QAM_64    = 2'h3;

  // ------------------------------------------------------------
  // Checksum generators
  // ------------------------------------------------------------
  localparam logic [15:0] HCRC_POLY = 16'h1021;
  localparam logic [15:0] HCRC_INIT = 16'hffff;
  localparam logic [31:0] FCRC_POLY = 32'h04c11db7;
  localparam logic [31:0] FCRC_INIT = 32'hffffffff;

  // ------------------------------------------------------------
  // Block tables, rates in hundredths
  // ------------------------------------------------------------
  localparam logic [SIZE_W-1:0] SIZE_TAB [NUM_TYPES] = '{
    9'h00f, 9'h03c, 9'h021, 9'h025, 9'h02c, 9'h0b0,
    9'h049, 9'h124, 9'h058, 9'h160, 9'h068, 9'h1a0};
  localparam logic [RATE_W-1:0] RATE_LO [NUM_TYPES] = '{
    7'h4b, 7'h4b, 7'h37, 7'h3e, 7'h37, 7'h37,
    7'h34, 7'h34, 7'h37, 7'h37, 7'h41, 7'h41};
  localparam logic [RATE_W-1:0] RATE_32 [NUM_TYPES] = '{
    7'h50, 7'h50, 7'h39, 7'h40, 7'h3a, 7'h3a,
    7'h37, 7'h37, 7'h3a, 7'h3a, 7'h45, 7'h45};
  localparam logic [RATE_W-1:0] RATE_64 [NUM_TYPES] = '{
    7'h53, 7'h53, 7'h3d, 7'h45, 7'h3d, 7'h3d,
    7'h3a, 7'h3a, 7'h3d, 7'h3d, 7'h48, 7'h48};

  function automatic logic [SIZE_W-1:0] payload_len(
    input logic [SIZE_W-1:0] size,
    input qfb_kind_t         kind);
    case (kind)
      KIND_HEADER: payload_len = size - SIZE_W'(HDR_CRC_BYTES);
      KIND_LAST:   payload_len = size - SIZE_W'(FRM_CRC_BYTES);
      default:     payload_len = size;
    endcase
  endfunction : payload_len

endpackage : qfb_pkg

// >>> core/qfb_crc.sv
`timescale 1ns/1ps
module qfb_crc #(
  parameter int             W    = 16,
  parameter logic [W-1:0]   POLY = '0,
  parameter logic [W-1:0]   INIT = '1
) (
  input  wire logic         clock_in,
  input  wire logic         resetn_in,
  input  wire logic         clear_in,
  input  wire logic         en_in,
  input  wire logic [7:0]   byte_in,
  output logic      [W-1:0] crc_out
);

  logic [W-1:0] crc_d;

  // Bytes enter most significant bit first.
  always_comb begin
    crc_d = crc_out;
    for (int i = 7; i >= 0; i--) begin
      if (crc_d[W-1] ^ byte_in[i]) begin
        crc_d = (crc_d << 1) ^ POLY;
      end else begin
        crc_d = crc_d << 1;
      end
    end
  end

  // Clear wins over a byte in the same cycle.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      crc_out <= INIT;
    end else if (clear_in) begin
      crc_out <= INIT;
    end else if (en_in) begin
      crc_out <= crc_d;
    end
  end

endmodule : qfb_crc

// >>> core/qfb_framer.sv
`timescale 1ns/1ps
module qfb_framer #(
  parameter logic [qfb_pkg::SYNC_SYMBOLS-1:0] SYNC_WORD = 24'h3c5a96
) (
  input  wire logic                        clock_in,
  input  wire logic                        resetn_in,
  input  wire logic [1:0]                  qam_order_in,
  input  wire logic                        cfg_valid_in,
  input  wire logic [qfb_pkg::SIZE_W-1:0]  cfg_size_in,
  input  wire logic [qfb_pkg::RATE_W-1:0]  cfg_rate_in,
  input  wire logic                        tx_cmd_valid_in,
  input  wire logic [15:0]                 tx_cmd_in,
  output logic                             tx_cmd_ready_out,
  input  wire logic [7:0]                  tx_data_in,
  input  wire logic                        tx_data_valid_in,
  output logic                             tx_data_ready_out,
  output logic [7:0]                       tx_sym_out,
  output logic                             tx_sym_valid_out,
  output logic                             tx_sync_out,
  output logic [qfb_pkg::RATE_W-1:0]       tx_rate_out,
  output logic                             tx_reject_out,
  input  wire logic                        rx_cmd_valid_in,
  input  wire logic [15:0]                 rx_cmd_in,
  output logic                             rx_cmd_ready_out,
  input  wire logic [7:0]                  rx_sym_in,
  input  wire logic                        rx_sym_valid_in,
  output logic [7:0]                       rx_data_out,
  output logic                             rx_data_valid_out,
  output logic                             rx_crc_ok_out,
  output logic                             rx_crc_fail_out,
  output logic                             rx_reject_out
);
  import qfb_pkg::*;

  typedef enum logic [2:0] {T_IDLE, T_SYNC, T_DATA, T_CRC, T_PAD} qfb_tx_t;
  typedef enum logic [1:0] {R_IDLE, R_DATA, R_CRC, R_CHK} qfb_rx_t;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  // ------------------------------------------------------------
  // User block configuration
  // ------------------------------------------------------------
  logic              user_loaded_q;
  logic [SIZE_W-1:0] user_size_q;
  logic [RATE_W-1:0] user_rate_q;

  // A user size below five bytes leaves no last-block payload.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      user_loaded_q <= 1'b0;
      user_size_q   <= '0;
      user_rate_q   <= '0;
    end else if (cfg_valid_in) begin
      user_loaded_q <= 1'b1;
      user_size_q   <= cfg_size_in;
      user_rate_q   <= cfg_rate_in;
    end
  end

  function automatic logic type_ok(input logic [3:0] code);
    type_ok = (code < USER_TYPE) || user_loaded_q;
  endfunction : type_ok

  function automatic logic [SIZE_W-1:0] type_size(input logic [3:0] code);
    type_size = (code >= USER_TYPE) ? user_size_q : SIZE_TAB[code];
  endfunction : type_size

  function automatic logic [RATE_W-1:0] type_rate(
    input logic [3:0] code,
    input logic [1:0] order);
    if (code >= USER_TYPE) begin
      type_rate = user_rate_q;
    end else if (order == QAM_64) begin
      type_rate = RATE_64[code];
    end else if (order == QAM_32) begin
      type_rate = RATE_32[code];
    end else begin
      type_rate = RATE_LO[code];
    end
  endfunction : type_rate

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  logic [3:0] tx_code;
  logic [3:0] rx_code;
  qfb_kind_t  tx_kind;
  qfb_kind_t  rx_kind;
  logic       tx_take;
  logic       rx_take;
  logic       tx_cmd_ready_q;
  logic       rx_cmd_ready_q;

  assign tx_code = tx_cmd_in[TYPE_MSB:TYPE_LSB];
  assign rx_code = rx_cmd_in[TYPE_MSB:TYPE_LSB];
  assign tx_kind = qfb_kind_t'(tx_cmd_in[KIND_MSB:KIND_LSB]);
  assign rx_kind = qfb_kind_t'(rx_cmd_in[KIND_MSB:KIND_LSB]);
  assign tx_take = tx_cmd_valid_in && tx_cmd_ready_q;
  assign rx_take = rx_cmd_valid_in && rx_cmd_ready_q;

  // ------------------------------------------------------------
  // Checksums
  // ------------------------------------------------------------
  logic [15:0] tx_hcrc;
  logic [15:0] rx_hcrc;
  logic [31:0] tx_fcrc;
  logic [31:0] rx_fcrc;
  logic        tx_byte;
  logic        rx_byte;
  logic [7:0]  tx_crc_byte;
  qfb_tx_t     tx_state_q;
  qfb_rx_t     rx_state_q;
  qfb_kind_t   tx_kind_q;
  qfb_kind_t   rx_kind_q;
  logic [SIZE_W-1:0] tx_cnt_q;
  logic              tx_data_rdy_q;

  assign tx_byte = (tx_state_q == T_DATA) && tx_data_rdy_q && tx_data_valid_in;
  assign rx_byte = (rx_state_q == R_DATA) && rx_sym_valid_in;

  qfb_crc #(.W(16), .POLY(HCRC_POLY), .INIT(HCRC_INIT)) u_tx_hcrc (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .clear_in  (tx_take && (tx_kind == KIND_HEADER)),
    .en_in     (tx_byte && (tx_kind_q == KIND_HEADER)),
    .byte_in   (tx_data_in),
    .crc_out   (tx_hcrc)
  );
  qfb_crc #(.W(32), .POLY(FCRC_POLY), .INIT(FCRC_INIT)) u_tx_fcrc (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .clear_in  (tx_take && (tx_kind == KIND_CLEAR)),
    .en_in     (tx_byte && (tx_kind_q != KIND_HEADER)),
    .byte_in   (tx_data_in),
    .crc_out   (tx_fcrc)
  );
  qfb_crc #(.W(16), .POLY(HCRC_POLY), .INIT(HCRC_INIT)) u_rx_hcrc (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .clear_in  (rx_take && (rx_kind == KIND_HEADER)),
    .en_in     (rx_byte && (rx_kind_q == KIND_HEADER)),
    .byte_in   (rx_sym_in),
    .crc_out   (rx_hcrc)
  );
  qfb_crc #(.W(32), .POLY(FCRC_POLY), .INIT(FCRC_INIT)) u_rx_fcrc (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .clear_in  (rx_take && (rx_kind == KIND_CLEAR)),
    .en_in     (rx_byte && (rx_kind_q != KIND_HEADER)),
    .byte_in   (rx_sym_in),
    .crc_out   (rx_fcrc)
  );

  // Checksums leave most significant byte first.
  assign tx_crc_byte = (tx_kind_q == KIND_HEADER) ?
                       tx_hcrc[{~tx_cnt_q[0], 3'b000} +: 8] :
                       tx_fcrc[{~tx_cnt_q[1:0], 3'b000} +: 8];

  // ------------------------------------------------------------
  // Transmit formatter
  // ------------------------------------------------------------
  logic [SIZE_W-1:0] tx_len_q;
  logic [PAD_W-1:0]  tx_burst_q;
  logic [SIZE_W-1:0] tx_crc_last;
  logic [4:0]        sync_idx;

  assign tx_crc_last = (tx_kind_q == KIND_HEADER) ?
                       SIZE_W'(HDR_CRC_BYTES - 1) : SIZE_W'(FRM_CRC_BYTES - 1);
  assign sync_idx    = 5'(SYNC_SYMBOLS - 1) - tx_cnt_q[4:0];

  // The modulator never stalls; a host data gap only opens a gap.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_state_q       <= T_IDLE;
      tx_cmd_ready_q   <= 1'b1;
      tx_data_rdy_q    <= 1'b0;
      tx_kind_q        <= KIND_INTER;
      tx_len_q         <= '0;
      tx_cnt_q         <= '0;
      tx_burst_q       <= '0;
      tx_sym_out       <= 8'h00;
      tx_sym_valid_out <= 1'b0;
      tx_sync_out      <= 1'b0;
      tx_rate_out      <= '0;
      tx_reject_out    <= 1'b0;
    end else begin
      tx_sym_valid_out <= 1'b0;
      tx_sync_out      <= 1'b0;
      tx_reject_out    <= 1'b0;
      case (tx_state_q)
        T_IDLE: begin
          if (tx_take && (tx_kind != KIND_CLEAR)) begin
            if (!type_ok(tx_code)) begin
              tx_reject_out <= 1'b1;
            end else begin
              tx_cmd_ready_q <= 1'b0;
              tx_kind_q      <= tx_kind;
              tx_len_q       <= payload_len(type_size(tx_code), tx_kind);
              tx_rate_out    <= type_rate(tx_code, qam_order_in);
              tx_cnt_q       <= '0;
              if (tx_kind == KIND_HEADER) begin
                tx_burst_q <= '0;
                tx_state_q <= T_SYNC;
              end else begin
                tx_data_rdy_q <= 1'b1;
                tx_state_q    <= T_DATA;
              end
            end
          end
        end
        T_SYNC: begin
          tx_sym_out       <= {7'h00, SYNC_WORD[sync_idx]};
          tx_sym_valid_out <= 1'b1;
          tx_sync_out      <= 1'b1;
          tx_burst_q       <= tx_burst_q + 1'b1;
          if (tx_cnt_q == SIZE_W'(SYNC_SYMBOLS - 1)) begin
            tx_cnt_q      <= '0;
            tx_data_rdy_q <= 1'b1;
            tx_state_q    <= T_DATA;
          end else begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
          end
        end
        T_DATA: begin
          if (tx_byte) begin
            tx_sym_out       <= tx_data_in;
            tx_sym_valid_out <= 1'b1;
            tx_burst_q       <= tx_burst_q + 1'b1;
            if (tx_cnt_q == tx_len_q - 1'b1) begin
              tx_cnt_q      <= '0;
              tx_data_rdy_q <= 1'b0;
              if (tx_kind_q == KIND_INTER) begin
                tx_cmd_ready_q <= 1'b1;
                tx_state_q     <= T_IDLE;
              end else begin
                tx_state_q <= T_CRC;
              end
            end else begin
              tx_cnt_q <= tx_cnt_q + 1'b1;
            end
          end
        end
        T_CRC: begin
          tx_sym_out       <= tx_crc_byte;
          tx_sym_valid_out <= 1'b1;
          tx_burst_q       <= tx_burst_q + 1'b1;
          if (tx_cnt_q == tx_crc_last) begin
            tx_cnt_q <= '0;
            if ((tx_kind_q == KIND_HEADER) ||
                (tx_burst_q == PAD_W'(PAD_SYMBOLS - 1))) begin
              tx_cmd_ready_q <= 1'b1;
              tx_state_q     <= T_IDLE;
            end else begin
              tx_state_q <= T_PAD;
            end
          end else begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
          end
        end
        T_PAD: begin
          tx_sym_out       <= 8'h00;
          tx_sym_valid_out <= 1'b1;
          tx_burst_q       <= tx_burst_q + 1'b1;
          if (tx_burst_q == PAD_W'(PAD_SYMBOLS - 1)) begin
            tx_cmd_ready_q <= 1'b1;
            tx_state_q     <= T_IDLE;
          end
        end
        default: tx_state_q <= T_IDLE;
      endcase
    end
  end

  assign tx_cmd_ready_out  = tx_cmd_ready_q;
  assign tx_data_ready_out = tx_data_rdy_q;

  // ------------------------------------------------------------
  // Receive deformatter
  // ------------------------------------------------------------
  logic [SIZE_W-1:0] rx_len_q;
  logic [SIZE_W-1:0] rx_cnt_q;
  logic [31:0]       rx_got_q;
  logic [SIZE_W-1:0] rx_crc_last;

  assign rx_crc_last = (rx_kind_q == KIND_HEADER) ?
                       SIZE_W'(HDR_CRC_BYTES - 1) : SIZE_W'(FRM_CRC_BYTES - 1);

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_state_q        <= R_IDLE;
      rx_cmd_ready_q    <= 1'b1;
      rx_kind_q         <= KIND_INTER;
      rx_len_q          <= '0;
      rx_cnt_q          <= '0;
      rx_got_q          <= '0;
      rx_data_out       <= 8'h00;
      rx_data_valid_out <= 1'b0;
      rx_crc_ok_out     <= 1'b0;
      rx_crc_fail_out   <= 1'b0;
      rx_reject_out     <= 1'b0;
    end else begin
      rx_data_valid_out <= 1'b0;
      rx_crc_ok_out     <= 1'b0;
      rx_crc_fail_out   <= 1'b0;
      rx_reject_out     <= 1'b0;
      case (rx_state_q)
        R_IDLE: begin
          if (rx_take && (rx_kind != KIND_CLEAR)) begin
            if (!type_ok(rx_code)) begin
              rx_reject_out <= 1'b1;
            end else begin
              rx_cmd_ready_q <= 1'b0;
              rx_kind_q      <= rx_kind;
              rx_len_q       <= payload_len(type_size(rx_code), rx_kind);
              rx_cnt_q       <= '0;
              rx_state_q     <= R_DATA;
            end
          end
        end
        R_DATA: begin
          if (rx_byte) begin
            rx_data_out       <= rx_sym_in;
            rx_data_valid_out <= 1'b1;
            if (rx_cnt_q == rx_len_q - 1'b1) begin
              rx_cnt_q <= '0;
              if (rx_kind_q == KIND_INTER) begin
                rx_cmd_ready_q <= 1'b1;
                rx_state_q     <= R_IDLE;
              end else begin
                rx_state_q <= R_CRC;
              end
            end else begin
              rx_cnt_q <= rx_cnt_q + 1'b1;
            end
          end
        end
        R_CRC: begin
          if (rx_sym_valid_in) begin
            rx_got_q <= {rx_got_q[23:0], rx_sym_in};
            if (rx_cnt_q == rx_crc_last) begin
              rx_cnt_q   <= '0;
              rx_state_q <= R_CHK;
            end else begin
              rx_cnt_q <= rx_cnt_q + 1'b1;
            end
          end
        end
        R_CHK: begin
          if ((rx_kind_q == KIND_HEADER) ? (rx_got_q[15:0] == rx_hcrc)
                                         : (rx_got_q == rx_fcrc)) begin
            rx_crc_ok_out <= 1'b1;
          end else begin
            rx_crc_fail_out <= 1'b1;
          end
          rx_cmd_ready_q <= 1'b1;
          rx_state_q     <= R_IDLE;
        end
        default: rx_state_q <= R_IDLE;
      endcase
    end
  end

  assign rx_cmd_ready_out = rx_cmd_ready_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic tx_new;
  assign tx_new = tx_take && (tx_kind != KIND_CLEAR) && (tx_code < USER_TYPE);

  AST_SYNC_LEN: assert property (
    $rose(tx_sync_out) |-> tx_sync_out[*8] ##1 tx_sync_out[*8]
      ##1 tx_sync_out[*8] ##1 !tx_sync_out)
    else $error("sync run is not 24 symbols");
  AST_HDR_CRC: assert property (
    $fell(tx_data_ready_out) && (tx_kind_q == KIND_HEADER) |->
      ##1 tx_sym_valid_out ##1 (tx_sym_valid_out && tx_cmd_ready_out)
      ##1 !tx_sym_valid_out)
    else $error("header checksum is not two bytes");
  AST_LAST_CRC: assert property (
    $fell(tx_data_ready_out) && (tx_kind_q == KIND_LAST) |->
      ##1 tx_sym_valid_out[*4])
    else $error("frame checksum is not four bytes");
  AST_CLEAR: assert property (
    tx_take && (tx_kind == KIND_CLEAR) |=> tx_fcrc == FCRC_INIT)
    else $error("clear block did not restart checksum");
  AST_DELIVER: assert property (
    rx_byte |=> rx_data_valid_out && (rx_data_out == $past(rx_sym_in)))
    else $error("received byte not delivered");
  AST_REPORT: assert property (
    (rx_state_q == R_CHK) |=> (rx_crc_ok_out != rx_crc_fail_out))
    else $error("checksum verdict missing");
  AST_LEN: assert property (
    tx_new |=> tx_len_q == SIZE_TAB[$past(tx_code)] - (
      ($past(tx_kind) == KIND_HEADER) ? SIZE_W'(HDR_CRC_BYTES) :
      ($past(tx_kind) == KIND_LAST)   ? SIZE_W'(FRM_CRC_BYTES) :
                                        SIZE_W'(0)))
    else $error("payload length differs from table");
  AST_RATE: assert property (
    tx_new |=> tx_rate_out == (($past(qam_order_in) == QAM_64) ?
      RATE_64[$past(tx_code)] : ($past(qam_order_in) == QAM_32) ?
      RATE_32[$past(tx_code)] : RATE_LO[$past(tx_code)]))
    else $error("code rate differs from table");
  AST_USER: assert property (
    cfg_valid_in |=> user_loaded_q && (user_size_q == $past(cfg_size_in)))
    else $error("user block not loaded");
  AST_PAD: assert property (
    $rose(tx_cmd_ready_out) && (tx_kind_q == KIND_LAST) |-> tx_burst_q == '0)
    else $error("burst not a multiple of 16 symbols");
  AST_RESV: assert property (
    tx_take && (tx_kind != KIND_CLEAR) && (tx_code >= USER_TYPE)
      && !user_loaded_q |=> tx_reject_out && tx_cmd_ready_out)
    else $error("reserved type not refused");

endmodule : qfb_framer

// >>> verification/qfb_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host payload source
// ------------------------------------------------------------
module qfb_host_model (
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  input  wire logic       stall_in,
  input  wire logic       ready_in,
  output logic      [7:0] data_out,
  output logic            valid_out
);
  logic [7:0] n_q = 8'h00;
  logic       took;

  initial begin
    valid_out = 1'b0;
    data_out  = 8'hff;
  end

  // Bytes count up so the bench can predict every one. An offer is held
  // until taken; when stalling, one idle cycle follows each take and the
  // idle line shows the inverse so a stale byte never looks valid.
  always @(posedge clock_in) begin
    took = valid_out && ready_in;
    if (took) n_q = n_q + 8'h01;
    #1;
    valid_out = resetn_in && !(took && stall_in);
    data_out  = valid_out ? n_q : ~data_out;
  end
endmodule : qfb_host_model

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
  import qfb_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clock_in = 1'b0, resetn_in = 1'b0, stall = 1'b0, cfg_valid_in = 1'b0;
  logic tx_cmd_valid_in = 1'b0, rx_cmd_valid_in = 1'b0, rx_sym_valid_in = 1'b0;
  logic [1:0] qam_order_in = 2'h0;
  logic [SIZE_W-1:0] cfg_size_in = 9'h005;
  logic [RATE_W-1:0] cfg_rate_in = 7'h21, tx_rate_out;
  logic [15:0] tx_cmd_in = 16'h0000, rx_cmd_in = 16'h0000, h;
  logic [7:0] rx_sym_in = 8'h00, tx_data_in, tx_sym_out, rx_data_out;
  logic tx_data_valid_in, tx_cmd_ready_out, tx_data_ready_out, tx_sync_out;
  logic tx_sym_valid_out, tx_reject_out, rx_cmd_ready_out, rx_data_valid_out;
  logic rx_crc_ok_out, rx_crc_fail_out, rx_reject_out;
  logic [31:0] f;
  logic [8:0] txq[$];
  logic [7:0] rxq[$];
  int failures = 0, compares = 0, cyc = 0, nb = 0, oks = 0, bads = 0;
  int sz[12] = '{15, 60, 33, 37, 44, 176, 73, 292, 88, 352, 104, 416};
  // Arbitrary pattern, not the default, so the override is proven too.
  localparam logic [23:0] SYNC_W = 24'h1e6b4d;

  qfb_framer #(.SYNC_WORD(SYNC_W)) dut (.clock_in, .resetn_in,
    .qam_order_in, .cfg_valid_in,
    .cfg_size_in, .cfg_rate_in, .tx_cmd_valid_in, .tx_cmd_in,
    .tx_cmd_ready_out, .tx_data_in, .tx_data_valid_in, .tx_data_ready_out,
    .tx_sym_out, .tx_sym_valid_out, .tx_sync_out, .tx_rate_out,
    .tx_reject_out, .rx_cmd_valid_in, .rx_cmd_in, .rx_cmd_ready_out,
    .rx_sym_in, .rx_sym_valid_in, .rx_data_out, .rx_data_valid_out,
    .rx_crc_ok_out, .rx_crc_fail_out, .rx_reject_out);
  qfb_host_model host (.clock_in, .resetn_in, .stall_in(stall),
    .ready_in(tx_data_ready_out), .data_out(tx_data_in),
    .valid_out(tx_data_valid_in));

  // ------------------------------------------------------------
  // Clock, monitor and timeout
  // ------------------------------------------------------------
  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc++;
    if (tx_sym_valid_out === 1'b1) txq.push_back({tx_sync_out, tx_sym_out});
    if (rx_data_valid_out === 1'b1) rxq.push_back(rx_data_out);
    oks += (rx_crc_ok_out === 1'b1);
    bads += (rx_crc_fail_out === 1'b1);
    if (cyc == 40000) begin
      failures++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] crc(logic [31:0] c, logic [7:0] b,
                                      logic [31:0] p, int w);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[w-1] ^ b[i];
      c = c << 1;
      if (fb) c = c ^ p;
    end
    return c;
  endfunction : crc

  task cmd(input logic rx, input logic [1:0] k, input logic [3:0] t);
    @(posedge clock_in); #1;
    if (rx) begin
      rx_cmd_valid_in = 1'b1;
      rx_cmd_in = {4'h0, t, 6'h00, k};
    end else begin
      tx_cmd_valid_in = 1'b1;
      tx_cmd_in = {4'h0, t, 6'h00, k};
    end
    @(posedge clock_in); #1;
    rx_cmd_valid_in = 1'b0;
    tx_cmd_valid_in = 1'b0;
  endtask : cmd

  // Sends one block, waits for it to finish and checks its payload bytes.
  task tx_blk(input logic [1:0] k, input logic [3:0] t, input int off,
              input int np, input logic [RATE_W-1:0] r);
    int n;
    txq.delete();
    cmd(1'b0, k, t);
    check(tx_rate_out, r);
    n = 0;
    do begin
      @(posedge clock_in); #1;
      n++;
    end while (tx_cmd_ready_out !== 1'b1 && n < 3000);
    @(posedge clock_in); #1;
    for (int i = 0; i < np; i++) begin
      check(txq[off+i], {1'b0, 8'(nb)});
      h = 16'(crc(32'(h), 8'(nb), 32'h1021, 16));
      f = crc(f, 8'(nb), 32'h04c11db7, 32);
      nb++;
    end
  endtask : tx_blk

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reserved;
    cmd(1'b0, 2'h1, 4'hc);
    check(tx_reject_out, 1);
    cmd(1'b1, 2'h1, 4'hf);
    check(rx_reject_out, 1);
    check(tx_reject_out, 0);
    cfg_valid_in = 1'b1;
    @(posedge clock_in); #1;
    cfg_valid_in = 1'b0;
    tx_blk(2'h1, 4'hd, 0, 5, cfg_rate_in);
    check(txq.size(), 5);
  endtask : t_reserved

  task t_inter;
    for (int t = 0; t < 12; t++) begin
      qam_order_in = 2'(t);
      stall = (t % 2) == 1;
      tx_blk(2'h1, 4'(t), 0, sz[t], (t % 4) < 2 ? RATE_LO[t] :
             (t % 4) == 2 ? RATE_32[t] : RATE_64[t]);
      check(txq.size(), sz[t]);
    end
  endtask : t_inter

  task t_frame;
    qam_order_in = 2'h0;
    stall = 1'b0;
    cmd(1'b0, 2'h3, 4'h0);
    h = 16'hffff;
    tx_blk(2'h0, 4'h0, 24, 13, RATE_LO[0]);
    f = 32'hffffffff;
    for (int i = 0; i < 24; i++) check(txq[i], {8'h80, SYNC_W[23-i]});
    check({txq[37], txq[38]}, {1'b0, h[15:8], 1'b0, h[7:0]});
    check(txq.size(), 39);
    tx_blk(2'h1, 4'h0, 0, 15, RATE_LO[0]);
    tx_blk(2'h2, 4'h0, 0, 11, RATE_LO[0]);
    check({txq[11][7:0], txq[12][7:0], txq[13][7:0], txq[14][7:0]}, f);
    check(txq.size(), 26);
    for (int i = 15; i < 26; i++) check(txq[i], 9'h000);
  endtask : t_frame

  // Bit 0 of m corrupts the final checksum byte, bit 1 picks a header.
  task t_rx;
    logic [7:0]  b;
    logic [31:0] e;
    int          np;
    int          nc;
    for (int m = 0; m < 4; m++) begin
      np = m[1] ? 13 : 11;
      nc = m[1] ? 2 : 4;
      cmd(1'b1, 2'h3, 4'h0);
      cmd(1'b1, m[1] ? 2'h0 : 2'h2, 4'h0);
      f = 32'hffffffff;
      h = 16'hffff;
      rxq.delete();
      oks = 0;
      bads = 0;
      for (int i = 0; i < np + nc; i++) begin
        if (i < np) begin
          b = 8'h5a ^ 8'(i);
          f = crc(f, b, 32'h04c11db7, 32);
          h = 16'(crc(32'(h), b, 32'h1021, 16));
          e = m[1] ? {h, 16'h0000} : f;
        end else b = e[31-8*(i-np) -: 8] ^ 8'(m[0] && i == np + nc - 1);
        rx_sym_valid_in = 1'b1;
        rx_sym_in = b;
        @(posedge clock_in); #1;
      end
      rx_sym_valid_in = 1'b0;
      repeat (4) @(posedge clock_in);
      #1;
      check(rxq.size(), np);
      check(rxq[10], 8'h50);
      check(oks, 32'(m[0] == 0));
      check(bads, 32'(m[0]));
    end
  endtask : t_rx

  task print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (8) @(posedge clock_in);
    #1;
    resetn_in = 1'b1;
    check({tx_cmd_ready_out, rx_cmd_ready_out, tx_sym_valid_out}, 3'b110);
    t_reserved();
    t_inter();
    t_frame();
    t_rx();
    print_verdict();
  end
endmodule : tb
